// ==== hdl/etc_regs.svh ====
// register map, field positions, reset values and timing figures of the
// exposure timing controller; assumes a 20 MHz system clock
`ifndef ETC_REGS_SVH
`define ETC_REGS_SVH

// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define ETC_ADDR_CTRL 8'h00
`define ETC_ADDR_TIMER1 8'h04
`define ETC_ADDR_TIMER2 8'h08
`define ETC_ADDR_STATUS 8'h0C

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define ETC_CTRL_MODE_LSB 0
`define ETC_CTRL_MODE_MSB 1
`define ETC_CTRL_FMT8_BIT 4
`define ETC_TIMER_MSB 23
`define ETC_CTRL_RST 32'h0000_0001
`define ETC_TIMER1_RST 24'h00_03E8
`define ETC_TIMER2_RST 24'h00_5208

// ----------------------------------------------------------------
// timing figures (microseconds for limits, nanoseconds for delays)
// ----------------------------------------------------------------
`define ETC_CLK_MHZ 20
`define ETC_TIMER1_MIN_US 6
`define ETC_TIMER2_MIN_US 35
`define ETC_START_DLY_NS 3700
`define ETC_OVERHEAD_NS 94500
`define ETC_JITTER_MAX_NS 25000
`define ETC_FV_MARGIN_NS 1000

`endif

// ==== hdl/etc_pkg.sv ====
// types shared by the exposure timing controller
// assumes etc_regs.svh carries the numeric constants
package etc_pkg;

  // exposure control modes as written to the mode field
  typedef enum logic [1:0]
  {
    ETC_MODE_LEVEL = 2'b00,
    ETC_MODE_PROG = 2'b01,
    ETC_MODE_FREE = 2'b10,
    ETC_MODE_RSVD = 2'b11
  } etc_mode_t;

  // sequencer states
  typedef enum logic [2:0]
  {
    ETC_IDLE,
    ETC_DELAY,
    ETC_JITTER,
    ETC_EXPOSE,
    ETC_LEVEL,
    ETC_WAITFV,
    ETC_HIGH
  } etc_state_t;

  // settings latched at the start of each exposure cycle
  typedef struct packed
  {
    etc_mode_t mode;
    logic fmt8;
    logic [23:0] t1_us;
    logic [23:0] t2_us;
  } etc_cfg_t;

  // video word towards the frame grabber
  typedef struct packed
  {
    logic fval;
    logic dval;
    logic [9:0] pix0;
    logic [9:0] pix1;
  } etc_vid_t;

endpackage

// ==== hdl/etc_top.sv ====
// exposure timing controller: trigger, free-run and readout sequencing,
// APB register slave and dual-pixel video output
// assumes a 20 MHz CLK_SYS_IN, pixel inputs on that clock, and a trigger
// pin from the frame grabber that is asynchronous to it
`include "etc_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module etc_top
#(
  parameter int FRAME_CYC = 504008
)
(
  input wire logic CLK_SYS_IN,
  input wire logic RESET_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [7:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  input wire logic TRIG_IN,
  input wire logic [9:0] PIX_A_IN,
  input wire logic [9:0] PIX_B_IN,
  output logic FVAL_OUT,
  output logic DVAL_OUT,
  output logic [9:0] PIX0_OUT,
  output logic [9:0] PIX1_OUT
);

  // ----------------------------------------------------------------
  // derived cycle counts
  // ----------------------------------------------------------------
  localparam int CYC_PER_US = `ETC_CLK_MHZ;
  localparam int START_CYC = (`ETC_START_DLY_NS * `ETC_CLK_MHZ + 999) / 1000;
  localparam int OVH_CYC = (`ETC_OVERHEAD_NS * `ETC_CLK_MHZ + 999) / 1000;
  localparam int JIT_CYC = (`ETC_JITTER_MAX_NS * `ETC_CLK_MHZ) / 1000;
  localparam int FVM_CYC = (`ETC_FV_MARGIN_NS * `ETC_CLK_MHZ + 999) / 1000;

  generate
    if (FRAME_CYC < 1)
    begin : g_bad_frame
      $error("etc_top: FRAME_CYC must be at least 1");
    end
  endgenerate

  // microseconds to clock cycles, used for both timers
  function automatic logic [31:0] us_to_cyc(input logic [23:0] us);
    us_to_cyc = 32'({8'h00, us} * CYC_PER_US);
  endfunction

  // clamp a written timer to its least legal value
  function automatic logic [23:0] clamp_us(input logic [31:0] v,
                                           input logic [23:0] lo);
    logic [23:0] f;
    f = v[`ETC_TIMER_MSB:0];
    clamp_us = (f < lo) ? lo : f;
  endfunction

  // ----------------------------------------------------------------
  // trigger pin synchroniser and edge detect
  // ----------------------------------------------------------------
  logic trig_s1_r;
  logic trig_s2_r;
  logic trig_d_r;
  logic trig_rise;
  logic trig_fall;

  // first stage feeds only the second; edges come from later stages
  always_ff @(posedge CLK_SYS_IN)
  begin
    if (RESET_IN)
    begin
      trig_s1_r <= 1'b0;
      trig_s2_r <= 1'b0;
      trig_d_r <= 1'b0;
    end
    else
    begin
      trig_s1_r <= TRIG_IN;
      trig_s2_r <= trig_s1_r;
      trig_d_r <= trig_s2_r;
    end
  end

  assign trig_rise = trig_s2_r & ~trig_d_r;
  assign trig_fall = ~trig_s2_r & trig_d_r;

  // ----------------------------------------------------------------
  // APB register slave
  // ----------------------------------------------------------------
  etc_pkg::etc_cfg_t reg_r;
  etc_pkg::etc_cfg_t reg_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic slverr_r;
  logic slverr_nxt;
  logic apb_setup;
  logic hit;
  etc_pkg::etc_state_t st_r;
  etc_pkg::etc_vid_t vid_r;

  assign apb_setup = PSEL_IN & ~PENABLE_IN;
  assign hit = (PADDR_IN == `ETC_ADDR_CTRL) | (PADDR_IN == `ETC_ADDR_TIMER1)
             | (PADDR_IN == `ETC_ADDR_TIMER2) | (PADDR_IN == `ETC_ADDR_STATUS);

  // decode in setup, so the zero-wait access phase finds data ready
  always_comb
  begin
    reg_nxt = reg_r;
    prdata_nxt = prdata_r;
    slverr_nxt = slverr_r;
    if (apb_setup)
    begin
      slverr_nxt = ~hit;
      prdata_nxt = 32'h0000_0000;
      if (!PWRITE_IN)
      begin
        unique case (PADDR_IN)
          `ETC_ADDR_CTRL:
            prdata_nxt = {27'h000_0000, reg_r.fmt8, 2'b00, reg_r.mode};
          `ETC_ADDR_TIMER1: prdata_nxt = {8'h00, reg_r.t1_us};
          `ETC_ADDR_TIMER2: prdata_nxt = {8'h00, reg_r.t2_us};
          `ETC_ADDR_STATUS:
            prdata_nxt = {27'h000_0000, vid_r.fval, 1'b0, st_r};
          default: prdata_nxt = 32'h0000_0000;
        endcase
      end
    end
    // writes land on the completing edge of the access phase
    if (PSEL_IN && PENABLE_IN && PWRITE_IN)
    begin
      unique case (PADDR_IN)
        `ETC_ADDR_CTRL:
        begin
          // reserved code falls back to timed mode
          reg_nxt.mode = (PWDATA_IN[`ETC_CTRL_MODE_MSB:`ETC_CTRL_MODE_LSB]
                          == 2'b11) ? etc_pkg::ETC_MODE_PROG
                        : etc_pkg::etc_mode_t'(PWDATA_IN[
                          `ETC_CTRL_MODE_MSB:`ETC_CTRL_MODE_LSB]);
          reg_nxt.fmt8 = PWDATA_IN[`ETC_CTRL_FMT8_BIT];
        end
        `ETC_ADDR_TIMER1:
          reg_nxt.t1_us = clamp_us(PWDATA_IN,
                                   24'(`ETC_TIMER1_MIN_US));
        `ETC_ADDR_TIMER2:
          reg_nxt.t2_us = clamp_us(PWDATA_IN,
                                   24'(`ETC_TIMER2_MIN_US));
        default: reg_nxt = reg_r;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS_IN)
  begin
    if (RESET_IN)
    begin
      reg_r <= {2'(`ETC_CTRL_RST), 1'b0, `ETC_TIMER1_RST, `ETC_TIMER2_RST};
      prdata_r <= 32'h0000_0000;
      slverr_r <= 1'b0;
    end
    else
    begin
      reg_r <= reg_nxt;
      prdata_r <= prdata_nxt;
      slverr_r <= slverr_nxt;
    end
  end

  assign PRDATA_OUT = prdata_r;
  assign PREADY_OUT = 1'b1;
  assign PSLVERR_OUT = slverr_r & PSEL_IN & PENABLE_IN;

  // ----------------------------------------------------------------
  // exposure sequencer
  // ----------------------------------------------------------------
  etc_pkg::etc_state_t st_nxt;
  etc_pkg::etc_cfg_t cfg_r;
  etc_pkg::etc_cfg_t cfg_nxt;
  logic [31:0] cnt_r;
  logic [31:0] cnt_nxt;
  logic [15:0] fvlow_r;
  logic [15:0] fvlow_nxt;
  logic rd_go;
  logic fv_ok;

  // frame valid has been low long enough to start a new readout
  assign fv_ok = (fvlow_r >= 16'(FVM_CYC));

  always_comb
  begin
    st_nxt = st_r;
    cfg_nxt = cfg_r;
    cnt_nxt = cnt_r;
    rd_go = 1'b0;
    unique case (st_r)
      etc_pkg::ETC_IDLE:
      begin
        cfg_nxt = reg_r;
        unique case (reg_r.mode)
          etc_pkg::ETC_MODE_FREE:
          begin
            // trigger not looked at here
            st_nxt = etc_pkg::ETC_EXPOSE;
            cnt_nxt = us_to_cyc(reg_r.t1_us) + 32'(OVH_CYC) - 32'd1;
          end
          etc_pkg::ETC_MODE_LEVEL:
            if (trig_fall)
              st_nxt = etc_pkg::ETC_LEVEL;
          default:
            if (trig_rise && vid_r.fval)
            begin
              st_nxt = etc_pkg::ETC_JITTER;
              cnt_nxt = 32'd0;
            end
            else if (trig_rise)
            begin
              st_nxt = etc_pkg::ETC_DELAY;
              cnt_nxt = 32'(START_CYC) - 32'd1;
            end
        endcase
      end
      etc_pkg::ETC_DELAY:
        if (cnt_r == 32'd0)
        begin
          st_nxt = etc_pkg::ETC_EXPOSE;
          cnt_nxt = us_to_cyc(cfg_r.t1_us) + 32'(OVH_CYC) - 32'd1;
        end
        else
          cnt_nxt = cnt_r - 32'd1;
      etc_pkg::ETC_JITTER:
        // start once the old frame is out, never later than the bound
        if (!vid_r.fval || cnt_r == 32'(JIT_CYC) - 32'd1)
        begin
          st_nxt = etc_pkg::ETC_EXPOSE;
          cnt_nxt = us_to_cyc(cfg_r.t1_us) + 32'(OVH_CYC)
                  - cnt_r - 32'd2;
        end
        else
          cnt_nxt = cnt_r + 32'd1;
      etc_pkg::ETC_EXPOSE:
        if (cnt_r != 32'd0)
          cnt_nxt = cnt_r - 32'd1;
        else if (fv_ok)
        begin
          rd_go = 1'b1;
          st_nxt = (cfg_r.mode == etc_pkg::ETC_MODE_FREE)
                 ? etc_pkg::ETC_HIGH : etc_pkg::ETC_IDLE;
          cnt_nxt = us_to_cyc(cfg_r.t2_us) - 32'd1;
        end
        else
          st_nxt = etc_pkg::ETC_WAITFV;
      etc_pkg::ETC_LEVEL:
        if (trig_rise && fv_ok)
        begin
          rd_go = 1'b1;
          st_nxt = etc_pkg::ETC_IDLE;
        end
        else if (trig_rise)
          st_nxt = etc_pkg::ETC_WAITFV;
      etc_pkg::ETC_WAITFV:
        // readout held off until the previous frame has cleared
        if (fv_ok)
        begin
          rd_go = 1'b1;
          st_nxt = (cfg_r.mode == etc_pkg::ETC_MODE_FREE)
                 ? etc_pkg::ETC_HIGH : etc_pkg::ETC_IDLE;
          cnt_nxt = us_to_cyc(cfg_r.t2_us) - 32'd1;
        end
      etc_pkg::ETC_HIGH:
        if (cnt_r == 32'd0)
          st_nxt = etc_pkg::ETC_IDLE;
        else
          cnt_nxt = cnt_r - 32'd1;
      default:
        st_nxt = etc_pkg::ETC_IDLE;
    endcase
    // saturating count of cycles with frame valid low
    if (vid_r.fval)
      fvlow_nxt = 16'h0000;
    else
      fvlow_nxt = fv_ok ? fvlow_r : fvlow_r + 16'h0001;
  end

  always_ff @(posedge CLK_SYS_IN)
  begin
    if (RESET_IN)
    begin
      st_r <= etc_pkg::ETC_IDLE;
      cfg_r <= {2'(`ETC_CTRL_RST), 1'b0, `ETC_TIMER1_RST, `ETC_TIMER2_RST};
      cnt_r <= 32'h0000_0000;
      fvlow_r <= 16'h0000;
    end
    else
    begin
      st_r <= st_nxt;
      cfg_r <= cfg_nxt;
      cnt_r <= cnt_nxt;
      fvlow_r <= fvlow_nxt;
    end
  end

  // ----------------------------------------------------------------
  // readout and video output
  // ----------------------------------------------------------------
  logic [31:0] frm_r;
  logic [31:0] frm_nxt;
  etc_pkg::etc_vid_t vid_nxt;

  // two pixels each clock; 8-bit mode keeps the top bits of each
  always_comb
  begin
    frm_nxt = frm_r;
    if (rd_go)
      frm_nxt = 32'(FRAME_CYC);
    else if (frm_r != 32'd0)
      frm_nxt = frm_r - 32'd1;
    vid_nxt.fval = (frm_nxt != 32'd0);
    vid_nxt.dval = (frm_nxt != 32'd0);
    if (frm_nxt == 32'd0)
    begin
      vid_nxt.pix0 = 10'h000;
      vid_nxt.pix1 = 10'h000;
    end
    else if (cfg_r.fmt8)
    begin
      vid_nxt.pix0 = {2'b00, PIX_A_IN[9:2]};
      vid_nxt.pix1 = {2'b00, PIX_B_IN[9:2]};
    end
    else
    begin
      vid_nxt.pix0 = PIX_A_IN;
      vid_nxt.pix1 = PIX_B_IN;
    end
  end

  always_ff @(posedge CLK_SYS_IN)
  begin
    if (RESET_IN)
    begin
      frm_r <= 32'h0000_0000;
      vid_r <= '0;
    end
    else
    begin
      frm_r <= frm_nxt;
      vid_r <= vid_nxt;
    end
  end

  assign FVAL_OUT = vid_r.fval;
  assign DVAL_OUT = vid_r.dval;
  assign PIX0_OUT = vid_r.pix0;
  assign PIX1_OUT = vid_r.pix1;

endmodule // etc_top

`default_nettype wire

// ==== sim/etc_props.sv ====
// port checker for the exposure timing controller, bound to etc_top
// assumes the etc_top port names and its frame length parameter
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// checker
// ------------------------------------------------------------
module etc_props
#(
  parameter int FRAME_CYC = 504008
)
(
  input wire logic CLK_SYS_IN,
  input wire logic RESET_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic [7:0] PADDR_IN,
  input wire logic [31:0] PRDATA_OUT,
  input wire logic PREADY_OUT,
  input wire logic PSLVERR_OUT,
  input wire logic [9:0] PIX_A_IN,
  input wire logic [9:0] PIX_B_IN,
  input wire logic FVAL_OUT,
  input wire logic DVAL_OUT,
  input wire logic [9:0] PIX0_OUT,
  input wire logic [9:0] PIX1_OUT
);
  logic [31:0] hi_r, hi_nxt, lo_r, lo_nxt;
  logic bad_adr;
  default clocking @(posedge CLK_SYS_IN); endclocking
  default disable iff (RESET_IN);
  // unmapped: beyond status or not word aligned
  assign bad_adr = (PADDR_IN > 8'h0C) || (PADDR_IN[1:0] != 2'h0);
  // run lengths of frame valid high and low
  always_comb
  begin
    hi_nxt = FVAL_OUT ? hi_r + 32'h1 : 32'h0;
    lo_nxt = FVAL_OUT ? 32'h0 : lo_r + 32'h1;
  end
  // cleared in reset so a cut frame is not measured
  always_ff @(posedge CLK_SYS_IN)
  begin
    hi_r <= RESET_IN ? 32'h0 : hi_nxt;
    lo_r <= RESET_IN ? 32'h0 : lo_nxt;
  end
  slave_error_a: assert property (PSEL_IN && PENABLE_IN |->
    PSLVERR_OUT == bad_adr) else $error("error flag wrong");
  error_data_a: assert property (PSLVERR_OUT |->
    PRDATA_OUT == 32'h0) else $error("refused read not zero");
  access_ready_a: assert property (PSEL_IN && PENABLE_IN |->
    PREADY_OUT) else $error("access not ready");
  data_valid_a: assert property (DVAL_OUT == FVAL_OUT)
    else $error("data valid differs");
  pixel_format_a: assert property (FVAL_OUT |->
    (PIX0_OUT == $past(PIX_A_IN) && PIX1_OUT == $past(PIX_B_IN)) ||
    (PIX0_OUT == ($past(PIX_A_IN) >> 2) &&
    PIX1_OUT == ($past(PIX_B_IN) >> 2))) else $error("pixel wrong");
  frame_length_a: assert property ($fell(FVAL_OUT) |->
    hi_r == FRAME_CYC) else $error("frame length wrong");
  valid_margin_a: assert property ($rose(FVAL_OUT) |->
    lo_r >= 32'd20) else $error("frame valid low too short");
  reset_out_a: assert property ($fell(RESET_IN) |-> !FVAL_OUT &&
    PIX0_OUT == 10'h0 && PIX1_OUT == 10'h0 && !PSLVERR_OUT)
    else $error("outputs not reset");
  cover property ($rose(FVAL_OUT));
  cover property (PSLVERR_OUT);
  cover property ($fell(FVAL_OUT) && hi_r == FRAME_CYC);
endmodule // etc_props
bind etc_top etc_props #(.FRAME_CYC(FRAME_CYC)) u_props
(
  .CLK_SYS_IN(CLK_SYS_IN), .RESET_IN(RESET_IN), .PSEL_IN(PSEL_IN),
  .PENABLE_IN(PENABLE_IN), .PADDR_IN(PADDR_IN), .PRDATA_OUT(PRDATA_OUT),
  .PREADY_OUT(PREADY_OUT), .PSLVERR_OUT(PSLVERR_OUT),
  .PIX_A_IN(PIX_A_IN), .PIX_B_IN(PIX_B_IN), .FVAL_OUT(FVAL_OUT),
  .DVAL_OUT(DVAL_OUT), .PIX0_OUT(PIX0_OUT), .PIX1_OUT(PIX1_OUT)
);
`default_nettype wire

// ==== sim/etc_grabber.sv ====
// frame grabber model: makes the trigger pin from a request level
// assumes its own 400 ns link clock, unrelated to the system clock
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// trigger source
// ------------------------------------------------------------
module etc_grabber
(
  input wire logic want_hi_in,
  input wire logic early_in,
  input wire logic fval_in,
  output logic trig_out
);
  logic lclk = 1'b0;
  int hi_n = 0;
  int lo_n = 0;
  initial trig_out = 1'b0;
  // link clock, odd phase so edges never meet the system clock
  initial
  begin
    #130;
    forever #200 lclk = ~lclk;
  end
  // early lets a scenario cut into a frame on purpose
  always @(posedge lclk)
  begin
    lo_n <= fval_in ? 0 : lo_n + 1;
    hi_n <= trig_out ? hi_n + 1 : 0;
    // waiting out the frame keeps the period above frame plus exposure
    if (!trig_out && want_hi_in &&
        (early_in || lo_n >= 3))
      trig_out <= 1'b1;
    else if (trig_out && !want_hi_in && hi_n >= 10)
      trig_out <= 1'b0;
  end
endmodule // etc_grabber
`default_nettype wire

// ==== sim/etc_top_test.sv ====
// self-checking bench for the exposure timing controller
// assumes etc_top, the etc_grabber model and the bound etc_props
`include "etc_regs.svh"
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// bench top
// ------------------------------------------------------------
module etc_top_test;
  localparam int FC = 600;
  localparam int EXP6 = 6 * `ETC_CLK_MHZ + `ETC_OVERHEAD_NS / 50;
  localparam int DLY = `ETC_START_DLY_NS / 50;
  logic clk, rst, psel, pen, pwr, want_hi, early, perr, prdy, rerr;
  logic fval, dval, trig;
  logic [7:0] padr;
  logic [31:0] pwd, prd, rdv;
  logic [9:0] pa, pb, p0, p1;
  int miscompares = 0;
  int compares = 0;
  etc_top #(.FRAME_CYC(FC)) dut (.CLK_SYS_IN(clk), .RESET_IN(rst),
    .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(padr),
    .PWDATA_IN(pwd), .PRDATA_OUT(prd), .PREADY_OUT(prdy),
    .PSLVERR_OUT(perr), .TRIG_IN(trig), .PIX_A_IN(pa), .PIX_B_IN(pb),
    .FVAL_OUT(fval), .DVAL_OUT(dval), .PIX0_OUT(p0), .PIX1_OUT(p1));
  etc_grabber u_grab (.want_hi_in(want_hi), .early_in(early),
    .fval_in(fval), .trig_out(trig));
  // system clock, 50 ns
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic summarize();
    if (miscompares == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // bounded wait for trigger (sel) or frame valid to reach lvl
  task automatic wt(input logic sel, input logic lvl, output int n);
    n = 0;
    while ((sel ? trig : fval) !== lvl && n < 9000)
    begin
      @(posedge clk);
      n++;
    end
    if (n == 9000)
    begin
      miscompares++;
      summarize();
    end
  endtask
  // one transfer; idles a cycle after so strobes are never reassigned
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    padr <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (prdy !== 1'b1 && n < 50)
    begin
      @(posedge clk);
      n++;
    end
    if (n == 50)
    begin
      chk("pready", prdy, 1'b1);
      summarize();
    end
    rdv = prd;
    rerr = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  // trigger pulse; returns at the first edge that sees it high
  task automatic pulse(input logic e, output int n);
    early <= e;
    want_hi <= 1'b1;
    wt(1'b1, 1'b1, n);
    want_hi <= 1'b0;
  endtask
  task automatic t_regs();
    apb(0, `ETC_ADDR_CTRL, 0);
    chk("ctrl", rdv, `ETC_CTRL_RST);
    apb(0, `ETC_ADDR_TIMER1, 0);
    chk("t1", rdv, `ETC_TIMER1_RST);
    apb(0, `ETC_ADDR_TIMER2, 0);
    chk("t2", rdv, `ETC_TIMER2_RST);
    apb(1, `ETC_ADDR_TIMER1, 5);
    apb(0, `ETC_ADDR_TIMER1, 0);
    chk("t1min", rdv, `ETC_TIMER1_MIN_US);
    apb(1, `ETC_ADDR_TIMER2, 34);
    apb(0, `ETC_ADDR_TIMER2, 0);
    chk("t2min", rdv, `ETC_TIMER2_MIN_US);
    apb(1, `ETC_ADDR_CTRL, 3);
    apb(0, `ETC_ADDR_CTRL, 0);
    chk("rsvd", rdv, 1);
    apb(0, 8'h10, 0);
    chk("unmap", rerr, 1);
  endtask
  // trigger with frame valid low; the pin falls mid exposure
  task automatic t_idle(input logic f8, input logic [9:0] e0, e1);
    int n;
    apb(1, `ETC_ADDR_CTRL, {27'h0, f8, 4'h1});
    wt(1'b0, 1'b0, n);
    pulse(1'b0, n);
    wt(1'b0, 1'b1, n);
    chk("lat", 32'(n >= EXP6 + DLY + 1 &&
      n <= EXP6 + DLY + 8), 1);
    chk("pix0", p0, e0);
    chk("pix1", p1, e1);
  endtask
  // trigger cuts into the frame just started
  task automatic t_busy();
    int a, b;
    pulse(1'b1, a);
    chk("inframe", fval, 1);
    wt(1'b0, 1'b0, a);
    wt(1'b0, 1'b1, b);
    chk("busy", 32'(a + b >= EXP6 && a + b <= EXP6 + 8), 1);
  endtask
  task automatic t_level();
    int n;
    apb(1, `ETC_ADDR_CTRL, 0);
    pulse(1'b0, n);
    repeat (400) @(posedge clk);
    chk("lvl_lo", fval, 0);
    // sequencer must sit in the level state, frame valid low
    apb(0, `ETC_ADDR_STATUS, 0);
    chk("lvl_st", rdv, 32'h0000_0004);
    pulse(1'b0, n);
    wt(1'b0, 1'b1, n);
    chk("lvl_rd", 32'(n >= 2 && n <= 10), 1);
  endtask
  // free run period with a trigger raised that must be ignored;
  // the level frame still running is skipped, so a full period is timed;
  // low plus high of 41 us outlasts the scaled frame
  task automatic t_free();
    int a, b;
    apb(1, `ETC_ADDR_CTRL, 2);
    wt(1'b0, 1'b0, a);
    wt(1'b0, 1'b1, a);
    early <= 1'b1;
    want_hi <= 1'b1;
    wt(1'b0, 1'b0, a);
    wt(1'b0, 1'b1, b);
    chk("period", 32'(a + b >= EXP6 + 698 &&
      a + b <= EXP6 + 704), 1);
  endtask
  initial
  begin
    rst = 1'b1;
    psel = 1'b0;
    pen = 1'b0;
    pwr = 1'b0;
    padr = 8'h00;
    pwd = 32'h0;
    pa = 10'h3FF;
    pb = 10'h2AA;
    want_hi = 1'b0;
    early = 1'b0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_idle(1'b1, 10'h0FF, 10'h0AA);
    t_idle(1'b0, 10'h3FF, 10'h2AA);
    t_busy();
    t_level();
    t_free();
    summarize();
  end
endmodule // etc_top_test
`default_nettype wire
